// [logic/ptgs_map.svh]
// Purpose: offsets, reset values and codes of the reference pulse gear scaler
// Assumes: included by bare name
// Notes: offsets are parameter addresses on the fieldbus parameter port
`ifndef PTGS_MAP_SVH
`define PTGS_MAP_SVH
// ------------------------------------------------------------------
// parameter addresses
// ------------------------------------------------------------------
`define PTGS_ADDR_FORMAT 16'h0504
`define PTGS_ADDR_INVERT 16'h080E
`define PTGS_ADDR_DEN_A 16'h2606
`define PTGS_ADDR_NUM_A 16'h2608
`define PTGS_ADDR_PRESET 16'h260C
`define PTGS_ADDR_DEN_B 16'h2618
`define PTGS_ADDR_NUM_B 16'h261A
// ------------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------------
`define PTGS_RST_FORMAT 2'h0
`define PTGS_RST_INVERT 1'h0
`define PTGS_RST_PRESET 4'h0
`define PTGS_RST_RATIO 32'h0000_0001
`define PTGS_PRESET_MAX 16'h000B
`define PTGS_FORMAT_MAX 16'h0002
`define PTGS_INVERT_MAX 16'h0001
// ------------------------------------------------------------------
// signal formats and resolution
// ------------------------------------------------------------------
`define PTGS_FMT_QUAD 2'h0
`define PTGS_FMT_PULSE_DIR 2'h1
`define PTGS_FMT_CW_CCW 2'h2
`define PTGS_INC_PER_REV 32'h0002_0000
`endif

// [logic/ptgs_pkg.sv]
// Purpose: types shared by the reference pulse gear scaler
// Assumes: nothing
// Notes: constants live in ptgs_map.svh
package ptgs_pkg;
    // parameter port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } ptgs_par_req_t;
    // one decoded reference increment
    typedef struct packed {
        logic valid;
        logic up;
    } ptgs_step_t;
endpackage : ptgs_pkg

// [logic/ptgs_decoder.sv]
// Purpose: decodes the reference pulse input into single increments
// Assumes: channels synchronous to clk, at most one edge per channel per cycle
// Notes: one increment per cycle at most
`timescale 1ns/1ps
`default_nettype none
`include "ptgs_map.svh"
module ptgs_decoder
    import ptgs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] format,
    input wire logic invert,
    input wire logic chan_a,
    input wire logic chan_b,
    output ptgs_step_t step
);
    logic a_prev_reg;
    logic b_prev_reg;
    logic a_chg;
    logic b_chg;
    ptgs_step_t raw;

    assign a_chg = chan_a ^ a_prev_reg;
    assign b_chg = chan_b ^ b_prev_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
        end else begin
            a_prev_reg <= chan_a;
            b_prev_reg <= chan_b;
        end
    end

    always_comb begin
        raw = '0;
        case (format)
            `PTGS_FMT_QUAD: begin
                // every edge of either channel counts; a double edge is lost
                raw.valid = a_chg ^ b_chg;
                raw.up = chan_a ^ b_prev_reg;
            end
            `PTGS_FMT_PULSE_DIR: begin
                raw.valid = chan_a & ~a_prev_reg;
                raw.up = ~chan_b;
            end
            `PTGS_FMT_CW_CCW: begin
                // simultaneous cw and ccw edges cancel
                raw.valid = (chan_a & ~a_prev_reg) ^ (chan_b & ~b_prev_reg);
                raw.up = chan_a & ~a_prev_reg;
            end
            default: begin
                raw = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step <= '0;
        end else begin
            step.valid <= raw.valid;
            step.up <= raw.up ^ invert;
        end
    end

    sequence s_cw_edge;
        format == `PTGS_FMT_CW_CCW && !a_prev_reg && chan_a && !(chan_b && !b_prev_reg);
    endsequence
    property p_invert_now;
        @(posedge clk) disable iff (rst)
        s_cw_edge |=> step.valid && step.up == !$past(invert);
    endproperty
    a_invert_now: assert property (p_invert_now) else $error("cw edge misdirected");
endmodule : ptgs_decoder
`default_nettype wire

// [logic/ptgs_scaler.sv]
// Purpose: reference pulse input front end and electronic gear scaler
// Assumes: parameter port and inputs synchronous to clk
// Notes: one reference increment per cycle; result is two cycles after the input edge (decoder stage, then gear stage)
//
// What this block does
// - decode quadrature, pulse-direction or cw-ccw input
// - format writes refused while power stage enabled
// - new format becomes active at next power-up
// - invert setting reverses counting, factory off
// - inversion change applies to next increment
// - motor increments = reference times numerator over denominator
// - ratio switch input picks ratio a or b while preset selector is 0
// - preset selector 0 programmed, 1-11 fixed values
// - preset value of reference gives one revolution
// - motor resolution 131072 increments per revolution
// - negative numerator reverses motor direction
// - numerator a signed 32-bit, factory 1
// - denominator a 1 to 2147483647, factory 1
// - ratio b signed numerator, positive denominator, factory 1
// - ratio b latched on numerator b write
`timescale 1ns/1ps
`default_nettype none
`include "ptgs_map.svh"
module ptgs_scaler
    import ptgs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ptgs_par_req_t par_req,
    output logic [31:0] par_rdata,
    output logic par_ack,
    output logic par_err,
    input wire logic power_up,
    input wire logic power_stage_en,
    input wire logic ratio_switch,
    input wire logic quadrature_channel_a,
    input wire logic quadrature_channel_b,
    output logic motor_valid,
    output logic [31:0] motor_delta,
    output logic [31:0] motor_position,
    output logic [1:0] format_active
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] preset_steps(input logic [3:0] sel);
        case (sel)
            4'h1: preset_steps = 32'h0000_00C8;
            4'h2: preset_steps = 32'h0000_0190;
            4'h3: preset_steps = 32'h0000_01F4;
            4'h4: preset_steps = 32'h0000_03E8;
            4'h5: preset_steps = 32'h0000_07D0;
            4'h6: preset_steps = 32'h0000_0FA0;
            4'h7: preset_steps = 32'h0000_1388;
            4'h8: preset_steps = 32'h0000_2710;
            4'h9: preset_steps = 32'h0000_1000;
            4'hA: preset_steps = 32'h0000_2000;
            4'hB: preset_steps = 32'h0000_4000;
            default: preset_steps = `PTGS_RST_RATIO;
        endcase
    endfunction : preset_steps

    // denominators must stay strictly positive
    function automatic logic den_ok(input logic [31:0] v);
        den_ok = !v[31] && (v != 32'h0000_0000);
    endfunction : den_ok

    // ------------------------------------------------------------------
    // parameter registers
    // ------------------------------------------------------------------
    logic [1:0] format_reg;
    logic invert_reg;
    logic [3:0] preset_reg;
    logic [31:0] num_a_reg;
    logic [31:0] den_a_reg;
    logic [31:0] den_b_reg;
    logic [31:0] num_b_act_reg;
    logic [31:0] den_b_act_reg;
    logic hit_fmt;
    logic hit_inv;
    logic hit_den_a;
    logic hit_num_a;
    logic hit_pre;
    logic hit_den_b;
    logic hit_num_b;
    logic mapped;
    logic wr_ok;

    assign hit_fmt = par_req.addr == `PTGS_ADDR_FORMAT;
    assign hit_inv = par_req.addr == `PTGS_ADDR_INVERT;
    assign hit_den_a = par_req.addr == `PTGS_ADDR_DEN_A;
    assign hit_num_a = par_req.addr == `PTGS_ADDR_NUM_A;
    assign hit_pre = par_req.addr == `PTGS_ADDR_PRESET;
    assign hit_den_b = par_req.addr == `PTGS_ADDR_DEN_B;
    assign hit_num_b = par_req.addr == `PTGS_ADDR_NUM_B;
    assign mapped = hit_fmt | hit_inv | hit_den_a | hit_num_a | hit_pre | hit_den_b | hit_num_b;

    // write acceptance: range checks and the power stage lock
    always_comb begin
        wr_ok = mapped;
        if (hit_fmt) begin
            wr_ok = !power_stage_en && par_req.wdata <= {16'h0, `PTGS_FORMAT_MAX};
        end else if (hit_inv) begin
            wr_ok = par_req.wdata <= {16'h0, `PTGS_INVERT_MAX};
        end else if (hit_pre) begin
            wr_ok = par_req.wdata <= {16'h0, `PTGS_PRESET_MAX};
        end else if (hit_den_a || hit_den_b) begin
            wr_ok = den_ok(par_req.wdata);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            format_reg <= `PTGS_RST_FORMAT;
            invert_reg <= `PTGS_RST_INVERT;
            preset_reg <= `PTGS_RST_PRESET;
            num_a_reg <= `PTGS_RST_RATIO;
            den_a_reg <= `PTGS_RST_RATIO;
            den_b_reg <= `PTGS_RST_RATIO;
        end else if (par_req.wr && wr_ok) begin
            if (hit_fmt) begin
                format_reg <= par_req.wdata[1:0];
            end
            if (hit_inv) begin
                invert_reg <= par_req.wdata[0];
            end
            if (hit_pre) begin
                preset_reg <= par_req.wdata[3:0];
            end
            if (hit_num_a) begin
                num_a_reg <= par_req.wdata;
            end
            if (hit_den_a) begin
                den_a_reg <= par_req.wdata;
            end
            if (hit_den_b) begin
                den_b_reg <= par_req.wdata;
            end
        end
    end

    // ratio b in use changes only when its numerator arrives
    always_ff @(posedge clk) begin
        if (rst) begin
            num_b_act_reg <= `PTGS_RST_RATIO;
            den_b_act_reg <= `PTGS_RST_RATIO;
        end else if (par_req.wr && hit_num_b) begin
            num_b_act_reg <= par_req.wdata;
            den_b_act_reg <= den_b_reg;
        end
    end

    // format in use is only taken over at power-up
    always_ff @(posedge clk) begin
        if (rst) begin
            format_active <= `PTGS_RST_FORMAT;
        end else if (power_up) begin
            format_active <= format_reg;
        end
    end

    // ------------------------------------------------------------------
    // parameter read and answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            par_rdata <= 32'h0000_0000;
            par_ack <= 1'b0;
            par_err <= 1'b0;
        end else begin
            par_ack <= (par_req.wr && wr_ok) || (par_req.rd && mapped);
            par_err <= (par_req.wr && !wr_ok) || (par_req.rd && !mapped);
            if (par_req.rd) begin
                case (1'b1)
                    hit_fmt: par_rdata <= {30'h0, format_reg};
                    hit_inv: par_rdata <= {31'h0, invert_reg};
                    hit_pre: par_rdata <= {28'h0, preset_reg};
                    hit_num_a: par_rdata <= num_a_reg;
                    hit_den_a: par_rdata <= den_a_reg;
                    hit_num_b: par_rdata <= num_b_act_reg;
                    hit_den_b: par_rdata <= den_b_reg;
                    default: par_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // reference decoding
    // ------------------------------------------------------------------
    ptgs_step_t step;

    ptgs_decoder u_decoder (
        .clk(clk),
        .rst(rst),
        .format(format_active),
        .invert(invert_reg),
        .chan_a(quadrature_channel_a),
        .chan_b(quadrature_channel_b),
        .step(step)
    );

    // ------------------------------------------------------------------
    // gear scaling
    // ------------------------------------------------------------------
    logic signed [31:0] num_use;
    logic [31:0] den_use;
    logic signed [63:0] rem_reg;
    logic signed [63:0] sum;
    logic signed [63:0] quot;
    logic signed [63:0] rem_next;

    always_comb begin
        if (preset_reg != 4'h0) begin
            // one revolution per preset count of reference increments
            num_use = `PTGS_INC_PER_REV;
            den_use = preset_steps(preset_reg);
        end else if (ratio_switch) begin
            num_use = num_b_act_reg;
            den_use = den_b_act_reg;
        end else begin
            num_use = num_a_reg;
            den_use = den_a_reg;
        end
    end

    // signed numerator flips the sign of each step on its own
    always_comb begin
        sum = step.up ? rem_reg + 64'(num_use) : rem_reg - 64'(num_use);
        quot = sum / $signed({32'h0, den_use});
        rem_next = sum - quot * $signed({32'h0, den_use});
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rem_reg <= 64'sh0;
        end else if (step.valid) begin
            rem_reg <= rem_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            motor_valid <= 1'b0;
            motor_delta <= 32'h0000_0000;
            motor_position <= 32'h0000_0000;
        end else begin
            motor_valid <= step.valid;
            if (step.valid) begin
                motor_delta <= quot[31:0];
                motor_position <= motor_position + quot[31:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_fmt_locked;
        @(posedge clk) disable iff (rst)
        par_req.wr && hit_fmt && power_stage_en |=> $stable(format_reg) && par_err;
    endproperty
    a_fmt_locked: assert property (p_fmt_locked) else $error("format written while enabled");

    property p_fmt_hold;
        @(posedge clk) disable iff (rst)
        !power_up |=> $stable(format_active);
    endproperty
    a_fmt_hold: assert property (p_fmt_hold) else $error("format changed without power-up");

    property p_fmt_take;
        @(posedge clk) disable iff (rst)
        power_up |=> format_active == $past(format_reg);
    endproperty
    a_fmt_take: assert property (p_fmt_take) else $error("format not taken at power-up");

    property p_den_pos;
        @(posedge clk) disable iff (rst)
        den_ok(den_a_reg) && den_ok(den_b_reg) && den_ok(den_b_act_reg);
    endproperty
    a_den_pos: assert property (p_den_pos) else $error("denominator out of range");

    sequence s_den_b_then_num_b;
        par_req.wr && hit_den_b && den_ok(par_req.wdata) ##1 par_req.wr && hit_num_b;
    endsequence
    property p_ratio_b_latch;
        @(posedge clk) disable iff (rst)
        s_den_b_then_num_b |=> den_b_act_reg == $past(par_req.wdata, 2)
            && num_b_act_reg == $past(par_req.wdata);
    endproperty
    a_ratio_b_latch: assert property (p_ratio_b_latch) else $error("ratio b not latched");

    property p_den_b_alone;
        @(posedge clk) disable iff (rst)
        !(par_req.wr && hit_num_b) |=> $stable(den_b_act_reg) && $stable(num_b_act_reg);
    endproperty
    a_den_b_alone: assert property (p_den_b_alone) else $error("ratio b changed early");

    property p_motor_follow;
        @(posedge clk) disable iff (rst)
        step.valid |=> motor_valid ##0 motor_position == $past(motor_position) + motor_delta;
    endproperty
    a_motor_follow: assert property (p_motor_follow) else $error("motor increment lost");

    property p_preset_rev;
        @(posedge clk) disable iff (rst)
        step.valid && preset_reg == 4'h1 && rem_reg == 64'sh0 && step.up
            |=> motor_delta == 32'h0000_028F;
    endproperty
    a_preset_rev: assert property (p_preset_rev) else $error("preset scaling wrong");

    property p_rem_bound;
        @(posedge clk) disable iff (rst)
        step.valid |=> (rem_reg < $signed({32'h0, $past(den_use)}))
            && (-rem_reg < $signed({32'h0, $past(den_use)}));
    endproperty
    a_rem_bound: assert property (p_rem_bound) else $error("remainder exceeds denominator");

    property p_inv_take;
        @(posedge clk) disable iff (rst)
        par_req.wr && hit_inv && wr_ok |=> invert_reg == $past(par_req.wdata[0]);
    endproperty
    a_inv_take: assert property (p_inv_take) else $error("invert not taken");

    property p_den_refused;
        @(posedge clk) disable iff (rst)
        par_req.wr && (hit_den_a || hit_den_b) && !den_ok(par_req.wdata)
            |=> par_err && $stable(den_a_reg) && $stable(den_b_reg);
    endproperty
    a_den_refused: assert property (p_den_refused) else $error("denominator accepted");

    property p_pre_refused;
        @(posedge clk) disable iff (rst)
        par_req.wr && hit_pre && par_req.wdata > {16'h0, `PTGS_PRESET_MAX}
            |=> par_err && $stable(preset_reg);
    endproperty
    a_pre_refused: assert property (p_pre_refused) else $error("preset out of range");

    property p_num_b_taken;
        @(posedge clk) disable iff (rst)
        par_req.wr && hit_num_b |=> par_ack && !par_err;
    endproperty
    a_num_b_taken: assert property (p_num_b_taken) else $error("numerator b refused");
endmodule : ptgs_scaler
`default_nettype wire

// [verif/ptgs_pulse_source.sv]
// Purpose: external pulse source that drives the reference pulse input
// Assumes: channels change 1 ns after a rising clk edge
// Notes: stepped by hierarchical task calls; gap stretches pulses for slow sources
`timescale 1ns/1ps
`default_nettype none
module ptgs_pulse_source (
    input wire logic clk,
    output logic chan_a,
    output logic chan_b
);
    initial begin
        chan_a = 1'b0;
        chan_b = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // one reference increment in the given format
    task automatic step(input logic up, input logic [1:0] fmt, input int gap);
        tick(1);
        if (fmt == 2'h0) begin
            // gray walk: a leads b when counting up
            if ((chan_a == chan_b) == up) chan_a = ~chan_a;
            else chan_b = ~chan_b;
        end else if (fmt == 2'h1) begin
            chan_a = 1'b0;
            chan_b = ~up;
            tick(1);
            chan_a = 1'b1;
            tick(gap);
            chan_a = 1'b0;
        end else begin
            // falls are not counted, so parking both low is harmless
            chan_a = 1'b0;
            chan_b = 1'b0;
            tick(1);
            if (up) chan_a = 1'b1;
            else chan_b = 1'b1;
            tick(gap);
            chan_a = 1'b0;
            chan_b = 1'b0;
        end
    endtask : step
    // both channels move together, which the receiver must ignore
    task automatic glitch(input logic [1:0] fmt);
        tick(1);
        chan_a = ~chan_a;
        chan_b = ~chan_b;
        if (fmt == 2'h2) begin
            tick(1);
            chan_a = 1'b0;
            chan_b = 1'b0;
        end
    endtask : glitch
endmodule : ptgs_pulse_source
`default_nettype wire

// [verif/test_pulse_train_gear_scaler.sv]
// Purpose: self-checking bench of the reference pulse gear scaler
// Assumes: source model stepped by task calls, inputs move 1 ns after clk
// Notes: expected motor steps come from a longint model of the ratio
`timescale 1ns/1ps
`default_nettype none
`include "ptgs_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_pulse_train_gear_scaler;
    import ptgs_pkg::*;
    logic clk;
    logic rst;
    ptgs_par_req_t par_req;
    logic [31:0] par_rdata, motor_delta, motor_position;
    logic par_ack, par_err, power_up, power_stage_en, ratio_switch;
    logic chan_a, chan_b, motor_valid, inv;
    logic [1:0] format_active, fmt;
    int err_total, checks, preset;
    logic [31:0] got_q[$];
    longint rem, pos, num_a, den_a, num_b, den_b;
    int preset_tab[12] = '{0, 200, 400, 500, 1000, 2000,
                           4000, 5000, 10000, 4096, 8192, 16384};

    ptgs_scaler ptgs_scaler_i (.clk(clk), .rst(rst), .par_req(par_req),
        .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err), .power_up(power_up),
        .power_stage_en(power_stage_en), .ratio_switch(ratio_switch),
        .quadrature_channel_a(chan_a), .quadrature_channel_b(chan_b),
        .motor_valid(motor_valid), .motor_delta(motor_delta),
        .motor_position(motor_position), .format_active(format_active));
    ptgs_pulse_source ptgs_pulse_source_i (.clk(clk), .chan_a(chan_a), .chan_b(chan_b));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (motor_valid === 1'b1) got_q.push_back(motor_delta);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic do_reset();
        tick();
        rst = 1'b1;
        {rem, pos, preset, inv, fmt} = '0;
        {num_a, den_a, num_b, den_b} = {4{64'sh1}};
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
    endtask : do_reset
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic e);
        tick();
        par_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        tick();
        par_req = '0;
        `CHK({par_ack, par_err}, {~e, e})
    endtask : bus
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        bus(1'b1, a, d, e);
    endtask : wr
    // two writes on consecutive edges, strobe held high between them
    task automatic wr_pair(input logic [15:0] a0, input logic [31:0] d0,
                           input logic [15:0] a1, input logic [31:0] d1);
        tick();
        par_req = '{wr: 1'b1, rd: 1'b0, addr: a0, wdata: d0};
        tick();
        `CHK({par_ack, par_err}, 2'h2)
        par_req = '{wr: 1'b1, rd: 1'b0, addr: a1, wdata: d1};
        tick();
        par_req = '0;
        `CHK({par_ack, par_err}, 2'h2)
    endtask : wr_pair
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000, 1'b0);
        `CHK(par_rdata, x)
    endtask : rd
    task automatic power_cycle();
        tick();
        power_up = 1'b1;
        tick();
        power_up = 1'b0;
        tick();
    endtask : power_cycle
    // one increment through the source, judged against the ratio model
    task automatic step(input logic up, input int gap);
        longint n, dv, s, q;
        n = (preset != 0) ? 64'sd131072 : (ratio_switch ? num_b : num_a);
        dv = (preset != 0) ? longint'(preset_tab[preset]) : (ratio_switch ? den_b : den_a);
        s = rem + ((up ^ inv) ? n : -n);
        q = s / dv;
        rem = s - q * dv;
        pos = pos + q;
        got_q.delete();
        ptgs_pulse_source_i.step(up, fmt, gap);
        repeat (4) @(posedge clk);
        #1;
        `CHK(got_q.size(), 1)
        if (got_q.size() == 1) `CHK(got_q[0], q[31:0])
        `CHK(motor_position, pos[31:0])
    endtask : step
    task automatic no_step();
        got_q.delete();
        ptgs_pulse_source_i.glitch(fmt);
        repeat (4) @(posedge clk);
        #1;
        `CHK(got_q.size(), 0)
    endtask : no_step
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        rd(`PTGS_ADDR_FORMAT, 32'h0000_0000);
        rd(`PTGS_ADDR_INVERT, 32'h0000_0000);
        rd(`PTGS_ADDR_PRESET, 32'h0000_0000);
        rd(`PTGS_ADDR_NUM_A, 32'h0000_0001);
        rd(`PTGS_ADDR_DEN_A, 32'h0000_0001);
        rd(`PTGS_ADDR_NUM_B, 32'h0000_0001);
        rd(`PTGS_ADDR_DEN_B, 32'h0000_0001);
        bus(1'b0, 16'h0500, 32'h0000_0000, 1'b1);
        `CHK(format_active, 2'h0)
    endtask : t_reset
    task automatic t_format();
        tick();
        power_stage_en = 1'b1;
        wr(`PTGS_ADDR_FORMAT, 32'h0000_0001, 1'b1);
        rd(`PTGS_ADDR_FORMAT, 32'h0000_0000);
        power_stage_en = 1'b0;
        wr(`PTGS_ADDR_FORMAT, 32'h0000_0003, 1'b1);
        wr(`PTGS_ADDR_FORMAT, 32'h0000_0001, 1'b0);
        // still quadrature until the next switch-on
        step(1'b1, 1);
        step(1'b1, 1);
        step(1'b0, 1);
        step(1'b0, 1);
        no_step();
        no_step();
        `CHK(format_active, 2'h0)
        power_cycle();
        `CHK(format_active, 2'h1)
        fmt = 2'h1;
        step(1'b1, 1);
        step(1'b0, 3);
        wr(`PTGS_ADDR_FORMAT, 32'h0000_0002, 1'b0);
        power_cycle();
        `CHK(format_active, 2'h2)
        fmt = 2'h2;
        step(1'b1, 1);
        step(1'b0, 2);
        no_step();
    endtask : t_format
    task automatic t_invert();
        wr(`PTGS_ADDR_INVERT, 32'h0000_0001, 1'b0);
        inv = 1'b1;
        step(1'b1, 1);
        wr(`PTGS_ADDR_INVERT, 32'h0000_0002, 1'b1);
        rd(`PTGS_ADDR_INVERT, 32'h0000_0001);
        wr(`PTGS_ADDR_INVERT, 32'h0000_0000, 1'b0);
        inv = 1'b0;
        step(1'b1, 1);
    endtask : t_invert
    task automatic t_ratio_a();
        wr(`PTGS_ADDR_NUM_A, 32'h0000_0003, 1'b0);
        wr(`PTGS_ADDR_DEN_A, 32'h0000_0002, 1'b0);
        {num_a, den_a} = {64'sd3, 64'sd2};
        repeat (3) step(1'b1, 1);
        wr(`PTGS_ADDR_NUM_A, 32'hFFFF_FFFD, 1'b0);
        num_a = -3;
        step(1'b1, 1);
        step(1'b0, 1);
        wr(`PTGS_ADDR_DEN_A, 32'h0000_0000, 1'b1);
        wr(`PTGS_ADDR_DEN_A, 32'h8000_0000, 1'b1);
        rd(`PTGS_ADDR_DEN_A, 32'h0000_0002);
        wr(`PTGS_ADDR_NUM_A, 32'h8000_0000, 1'b0);
        rd(`PTGS_ADDR_NUM_A, 32'h8000_0000);
        wr(`PTGS_ADDR_NUM_A, 32'h7FFF_FFFF, 1'b0);
        wr(`PTGS_ADDR_DEN_A, 32'h7FFF_FFFF, 1'b0);
        {num_a, den_a} = {64'sh7FFF_FFFF, 64'sh7FFF_FFFF};
        step(1'b1, 1);
    endtask : t_ratio_a
    task automatic t_ratio_b();
        wr(`PTGS_ADDR_DEN_B, 32'h0000_0005, 1'b0);
        rd(`PTGS_ADDR_DEN_B, 32'h0000_0005);
        rd(`PTGS_ADDR_NUM_B, 32'h0000_0001);
        tick();
        ratio_switch = 1'b1;
        step(1'b1, 1);
        wr(`PTGS_ADDR_NUM_B, 32'h0000_0007, 1'b0);
        {num_b, den_b} = {64'sd7, 64'sd5};
        step(1'b1, 1);
        ratio_switch = 1'b0;
        step(1'b1, 1);
        ratio_switch = 1'b1;
        step(1'b0, 2);
        wr_pair(`PTGS_ADDR_DEN_B, 32'h0000_0003, `PTGS_ADDR_NUM_B, 32'hFFFF_FFFE);
        num_b = -2;
        den_b = 3;
        rd(`PTGS_ADDR_NUM_B, 32'hFFFF_FFFE);
        step(1'b1, 1);
        wr(`PTGS_ADDR_DEN_B, 32'h0000_0000, 1'b1);
    endtask : t_ratio_b
    task automatic t_preset();
        do_reset();
        `CHK(format_active, 2'h0)
        wr(`PTGS_ADDR_PRESET, 32'h0000_000C, 1'b1);
        wr(`PTGS_ADDR_PRESET, 32'h0000_0001, 1'b0);
        preset = 1;
        repeat (200) step(1'b1, 1);
        `CHK(motor_position, 32'h0002_0000)
        for (int k = 2; k <= 11; k++) begin
            wr(`PTGS_ADDR_PRESET, k, 1'b0);
            preset = k;
            step(1'b1, 1);
        end
    endtask : t_preset
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        {err_total, checks} = '0;
        {par_req, power_up, power_stage_en, ratio_switch} = '0;
        rst = 1'b1;
        do_reset();
        t_reset();
        t_format();
        t_invert();
        t_ratio_a();
        t_ratio_b();
        t_preset();
        complete_run();
    end
    // the scenarios need well under 10000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule : test_pulse_train_gear_scaler
`default_nettype wire
